/* File: rtl/bdf_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bdf_top (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         spi_variant,
  input  wire bdf_pkg::bdf_mode_e           mode,
  input  wire logic                         strap_pin_a,
  input  wire logic                         init_done,
  input  wire logic                         sleep_n_pin,
  input  wire logic                         strap_pin_a_wr,
  input  wire logic [1:0]                   strap_pin_a_wdata,
  input  wire logic                         clear_faults_cmd,
  input  wire logic                         spi_in_locked,
  input  wire logic                         offstate_comparator_out,
  input  wire logic [bdf_pkg::FAULT_W-1:0]  fault_evt,
  output logic [1:0]                        strap_pin_a_select_field,
  output logic                              offstate_strap_pin_a_en,
  output logic                              onstate_strap_pin_a_en,
  output logic                              current_regulation,
  output logic                              high_side_load,
  output logic [bdf_pkg::FAULT_W-1:0]       active_status_reg,
  output logic [bdf_pkg::FAULT_W-1:0]       standby_status_reg,
  output logic                              fault_digest_reg,
  output logic                              fault_out_n_o,
  output logic                              fault_out_n_oe
);

  logic                         strap_done_reg;
  logic                         strap_done_next;
  logic                         strap_lvl_reg;
  logic                         strap_lvl_next;
  logic [1:0]                   field_reg;
  logic [1:0]                   field_next;
  logic                         sleep_prev_reg;
  logic                         sleep_req;
  logic [1:0]                   strap_pin_a_sel;
  bdf_pkg::bdf_strap_pin_a_cfg_s       cfg;
  logic [bdf_pkg::FAULT_W-1:0]  status;
  logic                         summary;
  logic                         pull_low;
  logic                         oe_next;

  // Falling edge of the sleep pin is the sleep request
  assign sleep_req = sleep_prev_reg & ~sleep_n_pin;

  // Strap caught once after init; held for the rest of the session
  always_comb begin
    strap_done_next = strap_done_reg | init_done;
    strap_lvl_next  = strap_lvl_reg;
    if (init_done && !strap_done_reg) begin
      strap_lvl_next = strap_pin_a;
    end
  end

  // Field write takes effect on the next edge, any time
  always_comb begin
    field_next = field_reg;
    if (strap_pin_a_wr) begin
      field_next = strap_pin_a_wdata;
    end
  end

  // Strap maps to low-side load, off-state on, or disabled
  assign strap_pin_a_sel = spi_variant ? field_reg : {1'b0, strap_lvl_reg};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      strap_lvl_reg  <= 1'b0;
      field_reg      <= bdf_pkg::STRAP_PIN_A_RESET;
      sleep_prev_reg <= 1'b1;
    end else begin
      strap_done_reg <= strap_done_next;
      strap_lvl_reg  <= strap_lvl_next;
      field_reg      <= field_next;
      sleep_prev_reg <= sleep_n_pin;
    end
  end

  bdf_strap_pin_a_decode i_bdf_strap_pin_a_decode (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .strap_pin_a_sel (strap_pin_a_sel),
    .mode     (mode),
    .cfg_reg  (cfg)
  );

  bdf_fault_log i_bdf_fault_log (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .fault_evt        (fault_evt),
    .clear_faults_cmd (clear_faults_cmd),
    .sleep_req        (sleep_req),
    .status_reg       (status),
    .summary_reg      (summary)
  );

  // Fault pin: comparator pass-through or inverted summary; sleep releases
  always_comb begin
    pull_low = summary;
    if (cfg.offstate_strap_pin_a_en && (spi_in_locked || !spi_variant)) begin
      pull_low = ~offstate_comparator_out;
    end
    oe_next = pull_low & sleep_n_pin;
  end

  // All outputs registered; status reflects the log one cycle later, except standby bit 7, which carries the comparator
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strap_pin_a_select_field  <= bdf_pkg::STRAP_PIN_A_RESET;
      offstate_strap_pin_a_en   <= 1'b0;
      onstate_strap_pin_a_en    <= 1'b0;
      current_regulation <= 1'b0;
      high_side_load     <= 1'b0;
      active_status_reg  <= bdf_pkg::FAULT_RESET;
      standby_status_reg <= bdf_pkg::FAULT_RESET;
      fault_digest_reg   <= 1'b0;
      fault_out_n_o      <= 1'b0;
      fault_out_n_oe     <= 1'b0;
    end else begin
      strap_pin_a_select_field  <= field_reg;
      offstate_strap_pin_a_en   <= cfg.offstate_strap_pin_a_en;
      onstate_strap_pin_a_en    <= cfg.onstate_strap_pin_a_en;
      current_regulation <= cfg.sense_reg_en;
      high_side_load     <= cfg.high_side_load;
      active_status_reg  <= status;
      standby_status_reg <= {offstate_comparator_out, status[bdf_pkg::FAULT_W-2:0]};
      fault_digest_reg   <= summary;
      fault_out_n_o      <= 1'b0;
      fault_out_n_oe     <= oe_next;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/bdf_pkg.sv */
// What this block does
// - Hardwired variant captures strap level once at init, ignores later changes.
// - SPI variant holds diagnostic mode in a two-bit field of config register two.
// - Bridge modes: field zero disables off-state diagnostics; nonzero enables; on-state always.
// - Independent: zero low-side load with sense; two high-side load, no sense.
// - Diagnostic field writes accepted whenever SPI works, effective immediately.
// - Any fault pulls the open-drain fault output low, except in sleep or comparator pass-through.
// - Entering sleep releases the fault output.
// - SPI fault output is inverse of summary bit, except comparator pass-through case.
// - Each fault assertion logs into digest and status registers.
// - Logged bits clear only by clear-faults command, sleep request or reset.
// - Status bits identify every diagnosable fault uniquely.
// - Locked input register with off-state diagnostics drives comparator onto fault pin.
package bdf_pkg;

  localparam int          FAULT_W          = 8;
  localparam logic [1:0]  STRAP_PIN_A_RESET       = 2'h0;
  localparam logic [1:0]  STRAP_PIN_A_ZERO        = 2'h0;
  localparam logic [1:0]  STRAP_PIN_A_TWO         = 2'h2;
  localparam logic [7:0]  FAULT_RESET      = 8'h00;
  // Status bit positions, one per fault source
  localparam int          ST_OCP1          = 0;
  localparam int          ST_OCP2          = 1;
  localparam int          ST_TSD           = 2;
  localparam int          ST_OV            = 3;
  localparam int          ST_UV            = 4;
  localparam int          ST_ONLOAD1       = 5;
  localparam int          ST_ONLOAD2       = 6;
  localparam int          ST_OLP           = 7;

  typedef enum logic [1:0] {
    BDF_MODE_PHEN,
    BDF_MODE_PWM,
    BDF_MODE_INDEP
  } bdf_mode_e;

  typedef struct packed {
    logic offstate_strap_pin_a_en;
    logic onstate_strap_pin_a_en;
    logic sense_reg_en;
    logic high_side_load;
  } bdf_strap_pin_a_cfg_s;

endpackage

/* File: rtl/bdf_strap_pin_a_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module bdf_strap_pin_a_decode (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic [1:0]             strap_pin_a_sel,
  input  wire bdf_pkg::bdf_mode_e     mode,
  output var bdf_pkg::bdf_strap_pin_a_cfg_s  cfg_reg
);

  bdf_pkg::bdf_strap_pin_a_cfg_s cfg_next;

  // Mode table decode of the selection field
  always_comb begin
    cfg_next = '0;
    case (mode)
      bdf_pkg::BDF_MODE_PHEN,
      bdf_pkg::BDF_MODE_PWM: begin
        cfg_next.offstate_strap_pin_a_en = (strap_pin_a_sel != bdf_pkg::STRAP_PIN_A_ZERO);
        cfg_next.onstate_strap_pin_a_en  = 1'b1;
        cfg_next.sense_reg_en     = 1'b1;
      end
      bdf_pkg::BDF_MODE_INDEP: begin
        // Bit 0 enables off-state, bit 1 picks high-side load
        cfg_next.offstate_strap_pin_a_en = strap_pin_a_sel[0];
        cfg_next.high_side_load   = strap_pin_a_sel[1];
        cfg_next.onstate_strap_pin_a_en  = strap_pin_a_sel[1];
        cfg_next.sense_reg_en     = ~strap_pin_a_sel[1];
      end
      default: cfg_next = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/bdf_fault_log.sv */
`timescale 1ns/1ps
`default_nettype none
module bdf_fault_log (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic [bdf_pkg::FAULT_W-1:0]  fault_evt,
  input  wire logic                         clear_faults_cmd,
  input  wire logic                         sleep_req,
  output logic [bdf_pkg::FAULT_W-1:0]       status_reg,
  output logic                              summary_reg
);

  logic [bdf_pkg::FAULT_W-1:0] status_next;

  // Sticky capture; a new event wins over a clear in the same cycle
  always_comb begin
    status_next = status_reg;
    if (clear_faults_cmd || sleep_req) begin
      status_next = bdf_pkg::FAULT_RESET;
    end
    status_next = status_next | fault_evt;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_reg  <= bdf_pkg::FAULT_RESET;
      summary_reg <= 1'b0;
    end else begin
      status_reg  <= status_next;
      summary_reg <= |status_next;
    end
  end

endmodule
`default_nettype wire

/* File: test/bdf_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module bdf_chk (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               spi_variant,
  input wire bdf_pkg::bdf_mode_e mode,
  input wire logic               sleep_n_pin,
  input wire logic               strap_pin_a_wr,
  input wire logic [1:0]         strap_pin_a_wdata,
  input wire logic               clear_faults_cmd,
  input wire logic [7:0]         fault_evt,
  input wire logic [1:0]         strap_pin_a_select_field,
  input wire logic               offstate_strap_pin_a_en,
  input wire logic               onstate_strap_pin_a_en,
  input wire logic               current_regulation,
  input wire logic               high_side_load,
  input wire logic               fault_digest_reg,
  input wire logic               fault_out_n_oe
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Steps shared by the decode and sticky checks
  // Enables lag the visible field by one cycle, so the inputs must hold for two
  sequence s_held; $stable(strap_pin_a_select_field) && $stable(mode) && $stable(spi_variant); endsequence
  sequence s_quiet; !clear_faults_cmd && sleep_n_pin; endsequence
  property p_wr; strap_pin_a_wr && spi_variant |-> ##2 strap_pin_a_select_field == $past(strap_pin_a_wdata, 2); endproperty
  a_wr: assert property (p_wr) else $error("field write lost");
  property p_brg; spi_variant && mode != bdf_pkg::BDF_MODE_INDEP ##1 s_held ##1 s_held
    |-> offstate_strap_pin_a_en == (strap_pin_a_select_field != 2'h0) && onstate_strap_pin_a_en; endproperty
  a_brg: assert property (p_brg) else $error("bridge decode wrong");
  property p_ind; spi_variant && mode == bdf_pkg::BDF_MODE_INDEP && !strap_pin_a_select_field[0] ##1 s_held ##1 s_held
    |-> onstate_strap_pin_a_en == strap_pin_a_select_field[1] && high_side_load == strap_pin_a_select_field[1]
    && current_regulation != strap_pin_a_select_field[1] && !offstate_strap_pin_a_en; endproperty
  a_ind: assert property (p_ind) else $error("independent decode wrong");
  property p_log; fault_evt != 8'h00 |-> ##2 fault_digest_reg; endproperty
  a_log: assert property (p_log) else $error("fault not logged");
  property p_stk; s_quiet ##1 s_quiet ##0 fault_digest_reg |=> fault_digest_reg; endproperty
  a_stk: assert property (p_stk) else $error("log lost without clear");
  property p_clr; clear_faults_cmd && fault_evt == 8'h00 |-> ##2 !fault_digest_reg; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_pin; spi_variant && sleep_n_pin && $past(sleep_n_pin) && !offstate_strap_pin_a_en
    && !$past(offstate_strap_pin_a_en) |-> fault_out_n_oe == fault_digest_reg; endproperty
  a_pin: assert property (p_pin) else $error("pin differs from summary");
  property p_slp; !sleep_n_pin |=> !fault_out_n_oe; endproperty
  a_slp: assert property (p_slp) else $error("pin held in sleep");
endmodule
bind bdf_top bdf_chk i_bdf_chk (.core_clk, .rst_n, .spi_variant, .mode, .sleep_n_pin, .strap_pin_a_wr,
  .strap_pin_a_wdata, .clear_faults_cmd, .fault_evt, .strap_pin_a_select_field, .offstate_strap_pin_a_en, .onstate_strap_pin_a_en,
  .current_regulation, .high_side_load, .fault_digest_reg, .fault_out_n_oe);
`default_nettype wire

/* File: test/bdf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bdf_host_model (
  input  wire logic fault_out_n_o,
  input  wire logic fault_out_n_oe,
  output logic      fault_n_seen
);
  // Board pull-up: a released line reads high, never the last level
  assign fault_n_seen = fault_out_n_oe ? fault_out_n_o : 1'b1;
endmodule
`default_nettype wire

/* File: test/test_bdf_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_bdf_top;
  logic               core_clk = 1'b0, rst_n = 1'b0, spi_variant = 1'b0, strap_pin_a = 1'b0;
  logic               init_done = 1'b0, sleep_n_pin = 1'b1, strap_pin_a_wr = 1'b0, clear_faults_cmd = 1'b0;
  logic               spi_in_locked = 1'b0, offstate_comparator_out = 1'b0;
  logic [1:0]         strap_pin_a_wdata = 2'h0, strap_pin_a_select_field;
  logic [7:0]         fault_evt = 8'h00, active_status_reg, standby_status_reg;
  bdf_pkg::bdf_mode_e mode = bdf_pkg::BDF_MODE_PHEN;
  logic               offstate_strap_pin_a_en, onstate_strap_pin_a_en, current_regulation, high_side_load;
  logic               fault_digest_reg, fault_out_n_o, fault_out_n_oe, fault_n_seen;
  int                 err_count = 0, n_tests = 0, cycles = 0;
  bdf_top i_bdf_top (.core_clk, .rst_n, .spi_variant, .mode, .strap_pin_a, .init_done, .sleep_n_pin,
    .strap_pin_a_wr, .strap_pin_a_wdata, .clear_faults_cmd, .spi_in_locked, .offstate_comparator_out, .fault_evt,
    .strap_pin_a_select_field, .offstate_strap_pin_a_en, .onstate_strap_pin_a_en, .current_regulation, .high_side_load,
    .active_status_reg, .standby_status_reg, .fault_digest_reg, .fault_out_n_o, .fault_out_n_oe);
  bdf_host_model i_bdf_host_model (.fault_out_n_o, .fault_out_n_oe, .fault_n_seen);
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  // Hang guard, well above the fewer than two hundred cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Inputs move 1 ns after the edge, away from sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr_strap_pin_a(input logic [1:0] v);
    strap_pin_a_wdata = v;
    strap_pin_a_wr = 1'b1;
    cyc(1);
    strap_pin_a_wr = 1'b0;
    cyc(4);
  endtask
  task automatic pulse_evt(input logic [7:0] v, input logic clr);
    fault_evt = v;
    clear_faults_cmd = clr;
    cyc(1);
    fault_evt = 8'h00;
    clear_faults_cmd = 1'b0;
    cyc(2);
  endtask
  // Strap latched at the first init only, then comparator on the pin
  task automatic t_strap();
    // Strap never asks for high-side; it only sets the off-state enable
    strap_pin_a = 1'b1;
    init_done = 1'b1;
    cyc(1);
    init_done = 1'b0;
    strap_pin_a = 1'b0;
    cyc(4);
    `CHK("strap", 1'b1, offstate_strap_pin_a_en)
    init_done = 1'b1;
    cyc(4);
    `CHK("relatch", 1'b1, offstate_strap_pin_a_en)
    `CHK("olp low", 1'b0, fault_n_seen)
    offstate_comparator_out = 1'b1;
    cyc(3);
    `CHK("olp high", 1'b1, fault_n_seen)
    `CHK("cmp bit", 1'b1, standby_status_reg[7])
  endtask
  // Every field value in every mode
  task automatic t_strap_pin_a();
    logic [1:0] v;
    spi_variant = 1'b1;
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 4; i++) begin
        v = 2'(i);
        mode = bdf_pkg::bdf_mode_e'(m);
        wr_strap_pin_a(v);
        `CHK("field", v, strap_pin_a_select_field)
        `CHK("off", m < 2 ? v != 2'h0 : v[0], offstate_strap_pin_a_en)
        if (m < 2) begin
          `CHK("on", 1'b1, onstate_strap_pin_a_en)
        end else begin
          `CHK("hs", v[1], high_side_load)
          `CHK("reg", !v[1], current_regulation)
          `CHK("on ind", v[1], onstate_strap_pin_a_en)
        end
      end
    end
  endtask
  // Each source logs alone, sticks, then clears; sleep releases
  task automatic t_fault();
    mode = bdf_pkg::BDF_MODE_PHEN;
    offstate_comparator_out = 1'b0;
    wr_strap_pin_a(2'h0);
    for (int i = 0; i < 8; i++) begin
      pulse_evt(8'h01 << i, 1'b0);
      cyc(3);
      `CHK("log", 1'b1, fault_digest_reg)
      `CHK("pin", 1'b0, fault_n_seen)
      `CHK("status", 8'h01 << i, active_status_reg | standby_status_reg)
      pulse_evt(8'h00, 1'b1);
      `CHK("clear", 1'b0, fault_digest_reg)
      `CHK("pin clr", 1'b1, fault_n_seen)
    end
    pulse_evt(8'h02, 1'b1);
    `CHK("evt wins", 1'b1, fault_digest_reg)
    sleep_n_pin = 1'b0;
    cyc(2);
    `CHK("sleep pin", 1'b1, fault_n_seen)
    `CHK("sleep log", 1'b0, fault_digest_reg)
    sleep_n_pin = 1'b1;
    spi_in_locked = 1'b1;
    wr_strap_pin_a(2'h1);
    `CHK("olp spi", 1'b0, fault_n_seen)
  endtask
  // Mid-run reset empties log and field
  task automatic t_reset();
    pulse_evt(8'h04, 1'b0);
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(1);
    `CHK("rst field", 2'h0, strap_pin_a_select_field)
    `CHK("rst log", 1'b0, fault_digest_reg)
  endtask
  initial begin
    cyc(5);
    rst_n = 1'b1;
    t_strap();
    t_strap_pin_a();
    t_fault();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
